// ==== shared/rf_amp_consts.vh ====
// Constants shared by the amplifier interlock and fault logger
`ifndef RF_AMP_CONSTS_VH
`define RF_AMP_CONSTS_VH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_MASK 8'h0C
`define OFS_TIME 8'h10
`define OFS_LOG_PTR 8'h14
`define OFS_LOG_IDX 8'h18
`define OFS_LOG_DATA 8'h1C
`define OFS_EVT_TIME 8'h20

// Control register fields
`define CTRL_RF_EN_BIT 0
`define CTRL_REARM_BIT 1
`define CTRL_RESET_VAL 32'h0000_0000

// Interrupt status fields
`define IRQ_BIAS_BIT 0
`define IRQ_PATH_BIT 1
`define IRQ_WATER_BIT 2
`define IRQ_PERMIT_BIT 3
`define IRQ_FROZEN_BIT 4
`define IRQ_W 5
`define IRQ_MASK_RESET 5'h00

// Log entry layout: kind in the top two bits
`define KIND_FAST 2'h0
`define KIND_SLOW 2'h1
`define KIND_EVENT 2'h2

// Timing, in nanoseconds
`define CLK_PERIOD_NS 10
`define SEQ_STEP_NS 10000
`define FAST_PERIOD_NS 100000
`define SLOW_PERIOD_NS 10000000
`define TICK_PERIOD_NS 1000000

// Log geometry
`define LOG_DEPTH 1000
`define LOG_POST 500
`endif

// ==== core/log_ram.v ====
// Single-port-write, registered-read memory for the cyclic log
`timescale 1ns/1ns
module log_ram #(
	parameter DW = 32,
	parameter AW = 10,
	parameter DEPTH = 1000
) (
	// Clock and freeze
	input wire clk_in,
	input wire ce_in,
	// Write side
	input wire we_in,
	input wire [AW-1:0] waddr_in,
	input wire [DW-1:0] wdata_in,
	// Read side
	input wire [AW-1:0] raddr_in,
	output reg [DW-1:0] rdata_out
);
	// Storage, no reset so it maps onto block memory
	reg [DW-1:0] mem [0:DEPTH-1];

	// Write and registered read
	always @(posedge clk_in) begin
		if (ce_in) begin
			if (we_in) begin
				mem[waddr_in] <= wdata_in;
			end
			rdata_out <= mem[raddr_in];
		end
	end
endmodule

// ==== core/rf_amp_interlock_logger.v ====
// Protection interlock, shutdown sequencer and fault logger
`timescale 1ns/1ns
`include "rf_amp_consts.vh"

// Summary of operation
// - Path inhibit opens RF switch, stays ready
// - Bias inhibit drops RF, DC, ready
// - Bias trip recovers only: inhibit high, reset
// - Water flow fault forces full shutdown
// - Permit open: RF, then DC, then AC off
// - RF switch closes only on path permit
// - Log fast and slow parameters at rates
// - Time stamp each state change and fault
// - Cyclic log buffer overwrites oldest entry
// - Keep pre-fault and post-fault log samples
// - Respond within fast and slow limits
// - Inhibits gate RF switch directly
// - Reset taken from source holding control
module rf_amp_interlock_logger #(
	parameter PW = 16,
	parameter AW = 10,
	parameter DEPTH = `LOG_DEPTH,
	parameter POST = `LOG_POST,
	parameter FAST_DIV = `FAST_PERIOD_NS / `CLK_PERIOD_NS,
	parameter SLOW_DIV = `SLOW_PERIOD_NS / `CLK_PERIOD_NS,
	parameter TICK_DIV = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
	// Clock, reset, enable
	input wire ref_clk_in,
	input wire resetn_in,
	input wire ce_in,
	// Hardwired interlock pins, low means inhibit or open, except the water flow fault pin which is high when bad
	input wire rf_path_inhibit_in,
	input wire bias_supply_inhibit_in,
	input wire safety_permit_in,
	input wire water_flow_fault_in,
	// Reset command sources and control ownership
	input wire remote_mode_in,
	input wire reset_remote_in,
	input wire reset_local_in,
	// Monitored parameters from the converters, same clock
	input wire [PW-1:0] fast_param_in,
	input wire [PW-1:0] slow_param_in,
	// Register port
	input wire [7:0] addr_in,
	input wire [31:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	output reg [31:0] rdata_out,
	// Power and status controls
	output wire rf_switch_close_out,
	output reg dc_on_out,
	output reg ac_on_out,
	output reg ready_out,
	output reg irq_out
);
	// Sequencer step time in cycles, rounded down as it is a longest time
	localparam STEP_CYC = `SEQ_STEP_NS / `CLK_PERIOD_NS;

	// One-hot states
	localparam [5:0] S_RUN = 6'h01;
	localparam [5:0] S_BIAS = 6'h02;
	localparam [5:0] S_SEQ_RF = 6'h04;
	localparam [5:0] S_SEQ_DC = 6'h08;
	localparam [5:0] S_SEQ_AC = 6'h10;
	localparam [5:0] S_DOWN = 6'h20;

	// Reset release through two flops
	reg [1:0] rst_sync_r;
	wire rst_n = rst_sync_r[1];

	always @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_sync_r <= 2'h0;
		end else if (ce_in) begin
			// Frozen with the rest while the enable is low
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end

	// Two-flop synchronisers for the seven pins
	wire [4:0] pin_raw = {reset_local_in, reset_remote_in,
		water_flow_fault_in, safety_permit_in, bias_supply_inhibit_in};
	reg [4:0] pin_s1_r;
	reg [4:0] pin_s2_r;
	reg path_s1_r;
	reg path_s2_r;
	reg mode_s1_r;
	reg mode_s2_r;

	always @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_r <= 5'h00;
			pin_s2_r <= 5'h00;
			path_s1_r <= 1'b0;
			path_s2_r <= 1'b0;
			mode_s1_r <= 1'b0;
			mode_s2_r <= 1'b0;
		end else if (ce_in) begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
			path_s1_r <= rf_path_inhibit_in;
			path_s2_r <= path_s1_r;
			mode_s1_r <= remote_mode_in;
			mode_s2_r <= mode_s1_r;
		end
	end

	// Synchronised levels
	wire bias_ok = pin_s2_r[0];
	wire permit_ok = pin_s2_r[1];
	wire water_bad = pin_s2_r[2];
	wire path_ok = path_s2_r;

	// Reset command from whichever source owns control
	wire rst_cmd_lvl = mode_s2_r ? pin_s2_r[3] : pin_s2_r[4];
	reg rst_cmd_d_r;
	reg path_ok_d_r;
	wire rst_cmd = rst_cmd_lvl & ~rst_cmd_d_r;

	// Software registers
	reg [31:0] ctrl_r;
	reg [`IRQ_W-1:0] irq_stat_r;
	reg [`IRQ_W-1:0] irq_mask_r;
	reg [31:0] time_r;
	reg [31:0] evt_time_r;
	reg [5:0] state_r;
	reg [5:0] state_nxt;
	reg [31:0] step_cnt_r;

	// Full shutdown causes, either one
	wire full_fault = water_bad | ~permit_ok;

	// Next state; every state is polled each cycle, well inside limits
	always @* begin
		state_nxt = state_r;
		case (state_r)
			S_RUN: begin
				if (full_fault) begin
					state_nxt = S_SEQ_RF;
				end else if (!bias_ok) begin
					state_nxt = S_BIAS;
				end
			end
			S_BIAS: begin
				if (full_fault) begin
					state_nxt = S_SEQ_RF;
				end else if (bias_ok && rst_cmd) begin
					state_nxt = S_RUN;
				end
			end
			S_SEQ_RF: begin
				if (step_cnt_r == STEP_CYC - 1) begin
					state_nxt = S_SEQ_DC;
				end
			end
			S_SEQ_DC: begin
				if (step_cnt_r == STEP_CYC - 1) begin
					state_nxt = S_SEQ_AC;
				end
			end
			S_SEQ_AC: begin
				state_nxt = S_DOWN;
			end
			S_DOWN: begin
				// Restart needs permit, flow, bias and a reset command
				if (!full_fault && bias_ok && rst_cmd) begin
					state_nxt = S_RUN;
				end
			end
			default: begin
				state_nxt = S_DOWN;
			end
		endcase
	end

	// State, step timer and power outputs registered from next state
	always @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= S_DOWN;
			step_cnt_r <= 32'h0000_0000;
			rst_cmd_d_r <= 1'b0;
			path_ok_d_r <= 1'b0;
			dc_on_out <= 1'b0;
			ac_on_out <= 1'b0;
			ready_out <= 1'b0;
		end else if (ce_in) begin
			state_r <= state_nxt;
			rst_cmd_d_r <= rst_cmd_lvl;
			path_ok_d_r <= path_ok;
			if (state_nxt != state_r) begin
				step_cnt_r <= 32'h0000_0000;
			end else begin
				step_cnt_r <= step_cnt_r + 32'h0000_0001;
			end
			// Path inhibit leaves bias and ready alone
			dc_on_out <= (state_nxt == S_RUN) || (state_nxt == S_SEQ_RF);
			ac_on_out <= (state_nxt != S_SEQ_AC) && (state_nxt != S_DOWN);
			ready_out <= (state_nxt == S_RUN);
		end
	end

	// RF allowed by state and software, then gated by raw inhibit pins;
	// the pins bypass the synchronisers so an inhibit acts at once
	reg rf_allow_r;
	always @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rf_allow_r <= 1'b0;
		end else if (ce_in) begin
			rf_allow_r <= (state_nxt == S_RUN) & ctrl_r[`CTRL_RF_EN_BIT];
		end
	end
	assign rf_switch_close_out = rf_allow_r & rf_path_inhibit_in &
		bias_supply_inhibit_in;

	// Fault events
	wire ev_bias = (state_r == S_RUN) && (state_nxt == S_BIAS);
	wire ev_path = path_ok_d_r & ~path_ok;
	wire ev_full = (state_r != S_SEQ_RF) && (state_nxt == S_SEQ_RF);
	wire ev_state = state_nxt != state_r;
	wire ev_fault = ev_bias | ev_full;

	// Rate dividers and time base
	reg [31:0] fast_cnt_r;
	reg [31:0] slow_cnt_r;
	reg [31:0] tick_cnt_r;
	wire fast_tick = fast_cnt_r == FAST_DIV - 1;
	wire slow_tick = slow_cnt_r == SLOW_DIV - 1;
	wire ms_tick = tick_cnt_r == TICK_DIV - 1;

	// Log write control
	reg [AW-1:0] wptr_r;
	reg [AW-1:0] trig_ptr_r;
	reg [AW-1:0] ridx_r;
	reg [AW-1:0] post_cnt_r;
	reg post_run_r;
	reg frozen_r;
	reg fast_pend_r;
	reg slow_pend_r;
	reg evt_pend_r;
	reg [5:0] evt_state_r;
	reg [31:0] log_wdata;
	reg log_we;
	wire [31:0] log_q;

	// Write slot: events first, then fast, then slow samples
	always @* begin
		log_we = 1'b0;
		log_wdata = 32'h0000_0000;
		if (!frozen_r) begin
			if (evt_pend_r) begin
				log_we = 1'b1;
				log_wdata = {`KIND_EVENT, evt_state_r, evt_time_r[23:0]};
			end else if (fast_pend_r) begin
				log_we = 1'b1;
				log_wdata = {`KIND_FAST, {(30-PW){1'b0}}, fast_param_in};
			end else if (slow_pend_r) begin
				log_we = 1'b1;
				log_wdata = {`KIND_SLOW, {(30-PW){1'b0}}, slow_param_in};
			end
		end
	end

	// Counters, pending flags and freeze after the post-fault window
	always @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			fast_cnt_r <= 32'h0000_0000;
			slow_cnt_r <= 32'h0000_0000;
			tick_cnt_r <= 32'h0000_0000;
			wptr_r <= {AW{1'b0}};
			trig_ptr_r <= {AW{1'b0}};
			post_cnt_r <= {AW{1'b0}};
			post_run_r <= 1'b0;
			frozen_r <= 1'b0;
			fast_pend_r <= 1'b0;
			slow_pend_r <= 1'b0;
			evt_pend_r <= 1'b0;
			evt_state_r <= 6'h00;
		end else if (ce_in) begin
			fast_cnt_r <= fast_tick ? 32'h0000_0000 : fast_cnt_r + 32'h1;
			slow_cnt_r <= slow_tick ? 32'h0000_0000 : slow_cnt_r + 32'h1;
			tick_cnt_r <= ms_tick ? 32'h0000_0000 : tick_cnt_r + 32'h1;
			// New request wins over the clear by a write
			fast_pend_r <= fast_tick | (fast_pend_r & ~(log_we &
				~evt_pend_r));
			slow_pend_r <= slow_tick | (slow_pend_r & ~(log_we &
				~evt_pend_r & ~fast_pend_r));
			evt_pend_r <= ev_state | (evt_pend_r & ~log_we);
			if (ev_state) begin
				evt_state_r <= state_nxt;
			end
			if (log_we) begin
				// Wrap overwrites the oldest entry
				wptr_r <= (wptr_r == DEPTH - 1) ? {AW{1'b0}} :
					wptr_r + {{(AW-1){1'b0}}, 1'b1};
			end
			// Fault arms the post window; older entries stay
			if (ev_fault && !post_run_r && !frozen_r) begin
				post_run_r <= 1'b1;
				trig_ptr_r <= wptr_r;
				post_cnt_r <= POST[AW-1:0];
			end else if (post_run_r && log_we) begin
				if (post_cnt_r == {{(AW-1){1'b0}}, 1'b1}) begin
					post_run_r <= 1'b0;
					frozen_r <= 1'b1;
				end
				post_cnt_r <= post_cnt_r - {{(AW-1){1'b0}}, 1'b1};
			end else if (wr_in && addr_in == `OFS_CTRL &&
				wdata_in[`CTRL_REARM_BIT]) begin
				frozen_r <= 1'b0;
			end
		end
	end

	// Log storage
	log_ram #(
		.DW(32),
		.AW(AW),
		.DEPTH(DEPTH)
	) u_log (
		.clk_in(ref_clk_in),
		.ce_in(ce_in),
		.we_in(log_we),
		.waddr_in(wptr_r),
		.wdata_in(log_wdata),
		.raddr_in(ridx_r),
		.rdata_out(log_q)
	);

	// Interrupt causes
	wire [`IRQ_W-1:0] irq_set = {post_run_r && log_we &&
		post_cnt_r == {{(AW-1){1'b0}}, 1'b1},
		ev_full & ~permit_ok, ev_full & water_bad, ev_path, ev_bias};
	wire stat_rd = rd_in && addr_in == `OFS_IRQ_STAT;

	// Register writes, time base, sticky status with set over clear
	always @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= `CTRL_RESET_VAL;
			irq_mask_r <= `IRQ_MASK_RESET;
			irq_stat_r <= {`IRQ_W{1'b0}};
			time_r <= 32'h0000_0000;
			evt_time_r <= 32'h0000_0000;
			ridx_r <= {AW{1'b0}};
			irq_out <= 1'b0;
		end else if (ce_in) begin
			if (wr_in && addr_in == `OFS_CTRL) begin
				ctrl_r <= {31'h0, wdata_in[`CTRL_RF_EN_BIT]};
			end
			if (wr_in && addr_in == `OFS_IRQ_MASK) begin
				irq_mask_r <= wdata_in[`IRQ_W-1:0];
			end
			if (wr_in && addr_in == `OFS_LOG_IDX) begin
				ridx_r <= wdata_in[AW-1:0];
			end
			// Software sets the clock; otherwise it counts milliseconds
			if (wr_in && addr_in == `OFS_TIME) begin
				time_r <= wdata_in;
			end else if (ms_tick) begin
				time_r <= time_r + 32'h0000_0001;
			end
			if (ev_state || ev_path) begin
				evt_time_r <= time_r;
			end
			irq_stat_r <= irq_set | (stat_rd ? {`IRQ_W{1'b0}} : irq_stat_r);
			irq_out <= |((irq_set | (stat_rd ? {`IRQ_W{1'b0}} :
				irq_stat_r)) & irq_mask_r);
		end
	end

	// Read mux; unmapped addresses read zero
	always @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rdata_out <= 32'h0000_0000;
		end else if (ce_in) begin
			rdata_out <= 32'h0000_0000;
			if (rd_in) begin
				case (addr_in)
					`OFS_CTRL: rdata_out <= ctrl_r;
					`OFS_STATUS: begin
						rdata_out <= {16'h0, frozen_r, post_run_r, path_ok,
							water_bad, permit_ok, bias_ok, ready_out,
							3'h0, state_r};
					end
					`OFS_IRQ_STAT: rdata_out <= {27'h0, irq_stat_r};
					`OFS_IRQ_MASK: rdata_out <= {27'h0, irq_mask_r};
					`OFS_TIME: rdata_out <= time_r;
					`OFS_LOG_PTR: begin
						rdata_out <= {6'h0, trig_ptr_r, 6'h0, wptr_r};
					end
					`OFS_LOG_IDX: rdata_out <= {22'h0, ridx_r};
					`OFS_LOG_DATA: rdata_out <= log_q;
					`OFS_EVT_TIME: rdata_out <= evt_time_r;
					default: rdata_out <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule

// ==== sim/rf_amp_checker_sva.sv ====
// Assertion checker for the interlock power outputs
`timescale 1ns/1ns
module rf_amp_checker (
	// Clock and reset
	input wire ref_clk_in,
	input wire resetn_in,
	// Interlock pins
	input wire rf_path_inhibit_in,
	input wire bias_supply_inhibit_in,
	input wire safety_permit_in,
	input wire water_flow_fault_in,
	// Power and status outputs
	input wire rf_switch_close_out,
	input wire dc_on_out,
	input wire ac_on_out,
	input wire ready_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	reg [2:0] ok_n; // Cycles with all other pins healthy
	reg [10:0] off_n; // Cycles since DC went off
	wire pins_ok; // No bias, permit or water trouble
	assign pins_ok = bias_supply_inhibit_in && safety_permit_in
		&& !water_flow_fault_in;
	// Saturating helpers, so long waits need no long repetitions
	always @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ok_n <= 3'h0;
			off_n <= 11'h000;
		end else begin
			ok_n <= !pins_ok ? 3'h0 : (&ok_n ? ok_n : ok_n + 3'h1);
			off_n <= dc_on_out ? 11'h000 : (&off_n ? off_n : off_n + 11'h001);
		end
	end
	gate_open_a:
	assert property (!rf_path_inhibit_in || !bias_supply_inhibit_in
		|-> !rf_switch_close_out) else $error("switch closed while inhibited");
	path_ready_a:
	assert property ($fell(rf_path_inhibit_in) && ready_out && ok_n == 3'h7
		|=> ready_out [*2]) else $error("ready lost on path inhibit");
	bias_trip_a:
	assert property (ready_out && $fell(bias_supply_inhibit_in) && pins_ok == 1'h0
		&& safety_permit_in && !water_flow_fault_in
		|-> ##[1:4] (!ready_out && !dc_on_out && ac_on_out))
		else $error("bias trip did not drop DC and ready");
	bias_hold_a:
	assert property (!dc_on_out && !bias_supply_inhibit_in |=> !dc_on_out)
		else $error("DC back on while bias inhibited");
	water_off_a:
	assert property (ready_out && $rose(water_flow_fault_in)
		|-> ##[1:4] (!ready_out && dc_on_out)) else $error("no water shutdown");
	permit_seq_a:
	assert property (ready_out && $fell(safety_permit_in)
		|-> ##[1:4] (!ready_out && dc_on_out && ac_on_out))
		else $error("permit loss did not start with RF");
	rf_first_a:
	assert property ($fell(ready_out) && dc_on_out && ac_on_out
		|=> dc_on_out [*8]) else $error("DC dropped with RF");
	ac_last_a:
	assert property ($fell(ac_on_out) |-> !rf_switch_close_out && !ready_out
		&& off_n >= 11'h3E6) else $error("AC dropped before DC step");
	cover property ($fell(ac_on_out));
	cover property ($fell(dc_on_out) && ac_on_out);
	cover property ($fell(rf_path_inhibit_in) && ready_out);
endmodule
bind rf_amp_interlock_logger rf_amp_checker u_rf_amp_checker (
	.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
	.rf_path_inhibit_in(rf_path_inhibit_in),
	.bias_supply_inhibit_in(bias_supply_inhibit_in),
	.safety_permit_in(safety_permit_in),
	.water_flow_fault_in(water_flow_fault_in),
	.rf_switch_close_out(rf_switch_close_out), .dc_on_out(dc_on_out),
	.ac_on_out(ac_on_out), .ready_out(ready_out));

// ==== sim/interlock_unit_model.sv ====
// External interlock unit model driving the inhibit lines
`timescale 1ns/1ns
module interlock_unit_model (
	// Clock and commands
	input wire logic clk_in,
	input wire logic fault_in,
	input wire logic crit_in,
	input wire logic trip_in,
	// Inhibit lines, low means inhibit
	output logic rf_drive_inhibit_out,
	output logic rf_path_inhibit_out,
	output logic bias_supply_inhibit_out
);
	// Healthy levels from time zero
	initial begin
		rf_drive_inhibit_out = 1'h1;
		rf_path_inhibit_out = 1'h1;
		bias_supply_inhibit_out = 1'h1;
	end
	// Lines follow commands one edge later; clearing raises them all
	always @(posedge clk_in) begin
		rf_drive_inhibit_out <= !(fault_in || crit_in);
		rf_path_inhibit_out <= !(fault_in || crit_in);
		bias_supply_inhibit_out <= !(crit_in || trip_in);
	end
endmodule

// ==== sim/tb.sv ====
// Self-checking bench for the interlock and fault logger
`timescale 1ns/1ns
`include "rf_amp_consts.vh"
module tb;
	// Clock, reset and interlock unit commands
	logic ref_clk_in = 1'h0, resetn_in = 1'h0;
	logic fault = 1'h0, crit = 1'h0, trip = 1'h0;
	// Inputs driven by the bench
	logic safety_permit_in = 1'h1, water_flow_fault_in = 1'h0;
	logic remote_mode_in = 1'h0, reset_remote_in = 1'h0, reset_local_in = 1'h0;
	logic [15:0] fast_param_in = 16'h0, slow_param_in = 16'h0;
	logic [7:0] addr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0, d, p, v;
	logic wr_in = 1'h0, rd_in = 1'h0;
	// Outputs and pins from the model
	wire [31:0] rdata_out;
	wire rf_path_inhibit_in, bias_supply_inhibit_in, rf_switch_close_out;
	wire dc_on_out, ac_on_out, ready_out, irq_out;
	wire [31:0] pwr = {28'h0, rf_switch_close_out, ready_out, dc_on_out, ac_on_out};
	int n_mismatch = 0, tests_run = 0;
	always #5 ref_clk_in = ~ref_clk_in;
	interlock_unit_model u_interlock_unit_model (.clk_in(ref_clk_in),
		.fault_in(fault), .crit_in(crit), .trip_in(trip),
		.rf_drive_inhibit_out(), .rf_path_inhibit_out(rf_path_inhibit_in),
		.bias_supply_inhibit_out(bias_supply_inhibit_in));
	// Short counts keep the run brief
	rf_amp_interlock_logger #(.POST(8), .FAST_DIV(20), .SLOW_DIV(50),
		.TICK_DIV(30)) u_rf_amp_interlock_logger (.ref_clk_in, .resetn_in,
		.ce_in(1'h1), .rf_path_inhibit_in, .bias_supply_inhibit_in,
		.safety_permit_in, .water_flow_fault_in, .remote_mode_in,
		.reset_remote_in, .reset_local_in, .fast_param_in, .slow_param_in,
		.addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .rf_switch_close_out,
		.dc_on_out, .ac_on_out, .ready_out, .irq_out);
	// Fresh converter samples every cycle
	always @(posedge ref_clk_in) begin
		fast_param_in <= 16'($urandom);
		slow_param_in <= 16'($urandom);
	end
	task chk(input string nm, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] val);
		@(posedge ref_clk_in);
		addr_in <= a;
		wdata_in <= val;
		wr_in <= 1'h1;
		@(posedge ref_clk_in);
		wr_in <= 1'h0;
	endtask
	// Read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a);
		@(posedge ref_clk_in);
		addr_in <= a;
		rd_in <= 1'h1;
		@(posedge ref_clk_in);
		rd_in <= 1'h0;
		#1 d = rdata_out;
	endtask
	// Reset command pulse from one source, long enough for the synchroniser
	task cmd(input logic remote);
		@(posedge ref_clk_in);
		if (remote) reset_remote_in <= 1'h1;
		else reset_local_in <= 1'h1;
		repeat (4) @(posedge ref_clk_in);
		reset_remote_in <= 1'h0;
		reset_local_in <= 1'h0;
		step(8);
	endtask
	// State a settled fault leaves behind
	function logic [5:0] exp_state(input logic bias, permit, water);
		if (!permit || water) return 6'h20;
		return bias ? 6'h01 : 6'h02;
	endfunction
	task end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Watchdog, several times the expected run
	initial begin
		#300000;
		n_mismatch++;
		end_of_test;
	end
	initial begin
		void'($urandom(32'h6F4A));
		repeat (5) @(posedge ref_clk_in);
		resetn_in <= 1'h1;
		step(6);
		chk("pwr", pwr, 32'h0);
		rd(`OFS_CTRL); chk("ctrl", d, 32'h0);
		rd(`OFS_IRQ_MASK); chk("mask", d, 32'h0);
		cmd(0); chk("pwr", pwr, 32'h7);
		wr(`OFS_CTRL, 32'h1); step(2); chk("pwr", pwr, 32'hF);
		$display("power up done");
		@(posedge ref_clk_in) fault <= 1'h1;
		step(3); chk("pwr", pwr, 32'h7);
		step(6); chk("pwr", pwr, 32'h7);
		chk("irq", irq_out, 32'h0);
		wr(`OFS_IRQ_MASK, 32'h2); step(2); chk("irq", irq_out, 32'h1);
		rd(`OFS_IRQ_STAT); chk("stat", d, 32'h2);
		step(2); chk("irq", irq_out, 32'h0);
		@(posedge ref_clk_in) fault <= 1'h0;
		step(6); chk("pwr", pwr, 32'hF);
		$display("path inhibit done");
		@(posedge ref_clk_in) trip <= 1'h1;
		step(8); chk("pwr", pwr, 32'h1);
		rd(`OFS_STATUS); chk("state", d[5:0], exp_state(0, 1, 0));
		cmd(0); chk("pwr", pwr, 32'h1);
		@(posedge ref_clk_in) trip <= 1'h0;
		step(6); chk("pwr", pwr, 32'h1);
		cmd(1); chk("pwr", pwr, 32'h1);
		rd(`OFS_IRQ_STAT); chk("bias event", d[0], 32'h1);
		cmd(0); chk("pwr", pwr, 32'hF);
		$display("bias trip done");
		step(300);
		rd(`OFS_STATUS); chk("frozen", d[15], 32'h1);
		rd(`OFS_LOG_PTR); p = d;
		step(100);
		rd(`OFS_LOG_PTR); chk("kept", d, p);
		wr(`OFS_CTRL, 32'h3); step(2);
		rd(`OFS_STATUS); chk("frozen", d[15], 32'h0);
		rd(`OFS_LOG_PTR); p = d;
		step(200);
		rd(`OFS_LOG_PTR);
		chk("rate", 32'((d[9:0] - p[9:0]) inside {[12:15]}), 32'h1);
		$display("log done");
		@(posedge ref_clk_in) safety_permit_in <= 1'h0;
		step(8); chk("pwr", pwr, 32'h3);
		step(1000); chk("pwr", pwr, 32'h1);
		step(1000); chk("pwr", pwr, 32'h0);
		rd(`OFS_STATUS); chk("state", d[5:0], exp_state(1, 0, 0));
		@(posedge ref_clk_in) safety_permit_in <= 1'h1;
		cmd(0); chk("pwr", pwr, 32'hF);
		$display("permit done");
		@(posedge ref_clk_in) remote_mode_in <= 1'h1;
		water_flow_fault_in <= 1'h1;
		step(8); chk("pwr", pwr, 32'h3);
		step(2010); chk("pwr", pwr, 32'h0);
		rd(`OFS_STATUS); chk("state", d[5:0], exp_state(1, 1, 1));
		@(posedge ref_clk_in) water_flow_fault_in <= 1'h0;
		cmd(0); chk("pwr", pwr, 32'h0);
		cmd(1); chk("pwr", pwr, 32'hF);
		$display("water done");
		@(posedge ref_clk_in) crit <= 1'h1;
		step(8); chk("pwr", pwr, 32'h1);
		@(posedge ref_clk_in) crit <= 1'h0;
		cmd(1); chk("pwr", pwr, 32'hF);
		$display("critical done");
		// Time base counts one step per 30 cycles in this bench
		wr(`OFS_TIME, 32'h100);
		step(90);
		rd(`OFS_TIME);
		chk("time", 32'((d - 32'h100) inside {[3:4]}), 32'h1);
		$display("time base done");
		repeat (6) begin
			v = $urandom;
			wr(`OFS_LOG_IDX, v);
			rd(`OFS_LOG_IDX); chk("idx", d, {22'h0, v[9:0]});
			rd(8'h24 + 8'(4 * ($urandom % 55))); chk("unmapped", d, 32'h0);
		end
		$display("registers done");
		end_of_test;
	end
endmodule
